// ==== core/pixel_shading_correction.v ====
// Per-pixel dark offset and photo gain correction pipeline
// Contract
// - Standard gain coefficient capped at 1.5
// - Enhanced gain coefficient may reach 4.0
// - Enhanced range uses coarser gain step
// - Mode selects dark, gain, or both
// - Dark offset evens out dark pixel levels
// - Gain evens out bright uniform response
// - Factory set kept write protected
// - User set holds full coefficients, normally used
// - Offsets raise pixels to brightest dark average
// - Separate user areas per acquisition mode
`timescale 1ns/1ps
`include "pixel_shading_defs.vh"

module pixel_shading_correction #(
    parameter DATA_W = 12,
    parameter PIXELS = 16,
    parameter IDX_W = 4,
    parameter ENHANCED = 0
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control levels from the correction mode register
    input wire [1:0] correctionMode,
    input wire useUserSet,
    input wire singleLineMode,
    // Pixel stream from sensor readout
    input wire pixelValid,
    input wire lineStart,
    input wire [DATA_W-1:0] pixelIn,
    // Pixel stream to camera output
    output reg outValid,
    output reg outLineStart,
    output reg [DATA_W-1:0] pixelOut,
    // User coefficient write port
    input wire coeffWrite,
    input wire coeffSingleArea,
    input wire [IDX_W-1:0] coeffIndex,
    input wire [DATA_W-1:0] coeffOffset,
    input wire [`GAIN_WIDTH-1:0] coeffGain,
    // Factory coefficient load and lock
    input wire factoryLoad,
    input wire factoryLock,
    input wire [DATA_W-1:0] factoryOffset,
    input wire [`GAIN_WIDTH-1:0] factoryGain
);
    // Gain format of the chosen variant
    localparam [3:0] FRAC = ENHANCED ? `GAIN_FRAC_ENH : `GAIN_FRAC_STD;
    localparam [`GAIN_WIDTH-1:0] GMAX = ENHANCED ? `GAIN_MAX_ENH : `GAIN_MAX_STD;
    localparam [DATA_W-1:0] PMAX = {DATA_W{1'b1}};

    // Pipeline state
    reg [IDX_W-1:0] pixIndex;
    reg [1:0] modeS1;
    reg [1:0] modeS2;
    reg [DATA_W-1:0] pixS1;
    reg [DATA_W-1:0] pixS2;
    reg [2:0] validPipe;
    reg [2:0] startPipe;
    wire [IDX_W-1:0] curIndex;
    // Coefficient words from the store, then held for stage 2
    wire [DATA_W-1:0] ofs;
    wire [`GAIN_WIDTH-1:0] gainRaw;
    reg [DATA_W-1:0] ofsS2;
    reg [`GAIN_WIDTH-1:0] gainS2;
    // Arithmetic between stage 2 and the output register
    reg [`GAIN_WIDTH-1:0] gainClip;
    reg [DATA_W:0] sumOfs;
    reg [DATA_W-1:0] darkFixed;
    reg [DATA_W-1:0] gainInput;
    reg [DATA_W+`GAIN_WIDTH-1:0] product;
    reg [DATA_W+`GAIN_WIDTH-1:0] scaled;
    reg [DATA_W-1:0] result;
    reg [DATA_W-1:0] next_pixelOut;

    // Saturate a wide value to the pixel range
    function [DATA_W-1:0] sat;
        input [DATA_W+`GAIN_WIDTH-1:0] v;
        begin
            if (v > {{`GAIN_WIDTH{1'b0}}, PMAX})
                sat = PMAX;
            else
                sat = v[DATA_W-1:0];
        end
    endfunction

    // Mode decode: code adds the dark offset
    function usesDark;
        input [1:0] mode;
        begin
            usesDark = (mode == `MODE_DARK) || (mode == `MODE_BOTH);
        end
    endfunction

    // Mode decode: code applies the gain
    function usesGain;
        input [1:0] mode;
        begin
            usesGain = (mode == `MODE_GAIN) || (mode == `MODE_BOTH);
        end
    endfunction

    // Coefficient store
    shading_coeff_store #(
        .PIXELS(PIXELS),
        .IDX_W(IDX_W),
        .OFS_W(DATA_W),
        .GAIN_W(`GAIN_WIDTH)
    ) store (
        .clk(clk),
        .rst(rst),
        .readIndex(curIndex),
        .useUserSet(useUserSet),
        .singleLineMode(singleLineMode),
        .readOffset(ofs),
        .readGain(gainRaw),
        .writeEnable(coeffWrite),
        .writeSingleArea(coeffSingleArea),
        .writeIndex(coeffIndex),
        .writeOffset(coeffOffset),
        .writeGain(coeffGain),
        .factoryLoad(factoryLoad),
        .factoryLock(factoryLock),
        .factoryOffset(factoryOffset),
        .factoryGain(factoryGain)
    );

    // Pixel index within the line
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            pixIndex <= {IDX_W{1'b0}};
        else if (pixelValid)
            pixIndex <= lineStart ? {{(IDX_W-1){1'b0}}, 1'b1} : pixIndex + {{(IDX_W-1){1'b0}}, 1'b1};
    end

    // Read index for current pixel
    assign curIndex = lineStart ? {IDX_W{1'b0}} : pixIndex;

    // Stage 1 and 2: delay pixel and mode while coefficient is read
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pixS1 <= {DATA_W{1'b0}};
            pixS2 <= {DATA_W{1'b0}};
            modeS1 <= `MODE_OFF;
            modeS2 <= `MODE_OFF;
            validPipe <= 3'h0;
            startPipe <= 3'h0;
        end
        else
        begin
            pixS1 <= pixelIn;
            pixS2 <= pixS1;
            modeS1 <= correctionMode;
            modeS2 <= modeS1;
            validPipe <= {validPipe[1:0], pixelValid};
            startPipe <= {startPipe[1:0], lineStart && pixelValid};
        end
    end

    // Stage 2 coefficients: store answers one edge after the index,
    // so its word is held one more edge to meet pixS2
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ofsS2 <= {DATA_W{1'b0}};
            gainS2 <= {`GAIN_WIDTH{1'b0}};
        end
        else
        begin
            ofsS2 <= ofs;
            gainS2 <= gainRaw;
        end
    end

    // Dark offset stage, saturating at full scale
    always @*
    begin
        sumOfs = {1'b0, pixS2} + {1'b0, ofsS2};
        darkFixed = sumOfs[DATA_W] ? PMAX : sumOfs[DATA_W-1:0];
        gainInput = usesDark(modeS2) ? darkFixed : pixS2;
    end

    // Gain stage and result select
    always @*
    begin
        gainClip = (gainS2 > GMAX) ? GMAX : gainS2;
        product = {{`GAIN_WIDTH{1'b0}}, gainInput} * {{DATA_W{1'b0}}, gainClip};
        scaled = product >> FRAC;
        case (modeS2)
            `MODE_OFF: result = pixS2;
            `MODE_DARK: result = darkFixed;
            `MODE_GAIN: result = sat(scaled);
            `MODE_BOTH: result = sat(scaled);
            default: result = pixS2;
        endcase
        next_pixelOut = result;
    end

    // Stage 3: registered outputs
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pixelOut <= {DATA_W{1'b0}};
            outValid <= 1'b0;
            outLineStart <= 1'b0;
        end
        else
        begin
            pixelOut <= next_pixelOut;
            outValid <= validPipe[1];
            outLineStart <= startPipe[1];
        end
    end
endmodule // pixel_shading_correction

// ==== core/pixel_shading_defs.vh ====
// Constants for the pixel shading correction block
`ifndef PIXEL_SHADING_DEFS_VH
`define PIXEL_SHADING_DEFS_VH

// Correction mode codes
`define MODE_OFF 2'h0
`define MODE_DARK 2'h1
`define MODE_GAIN 2'h2
`define MODE_BOTH 2'h3

// Gain coefficient format: 10 bits, fraction bits and ceiling per range
`define GAIN_WIDTH 10
// Standard range: 8 fraction bits, ceiling 1.5
`define GAIN_FRAC_STD 4'h8
`define GAIN_MAX_STD 10'h180
// Enhanced range: 7 fraction bits (coarser step), ceiling 4.0
`define GAIN_FRAC_ENH 4'h7
`define GAIN_MAX_ENH 10'h200

// Coefficient store layout: bank bits
`define BANK_FACTORY 1'b0
`define BANK_USER 1'b1

// Pipeline latency in clock cycles
`define PIPE_LATENCY 3

`endif

// ==== core/shading_coeff_store.v ====
// Coefficient store: factory set (write protected) and user set, two areas
`timescale 1ns/1ps
`include "pixel_shading_defs.vh"

module shading_coeff_store #(
    parameter PIXELS = 16,
    parameter IDX_W = 4,
    parameter OFS_W = 12,
    parameter GAIN_W = 10
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Read side
    input wire [IDX_W-1:0] readIndex,
    input wire useUserSet,
    input wire singleLineMode,
    output reg [OFS_W-1:0] readOffset,
    output reg [GAIN_W-1:0] readGain,
    // Write side, user set only
    input wire writeEnable,
    input wire writeSingleArea,
    input wire [IDX_W-1:0] writeIndex,
    input wire [OFS_W-1:0] writeOffset,
    input wire [GAIN_W-1:0] writeGain,
    // Factory load port, honoured only before the set is locked
    input wire factoryLoad,
    input wire factoryLock,
    input wire [OFS_W-1:0] factoryOffset,
    input wire [GAIN_W-1:0] factoryGain
);
    // Flip-flop storage, index = area*PIXELS + pixel
    reg [OFS_W-1:0] factOfs [0:PIXELS-1];
    reg [GAIN_W-1:0] factGain [0:PIXELS-1];
    reg [OFS_W-1:0] userOfs [0:2*PIXELS-1];
    reg [GAIN_W-1:0] userGain [0:2*PIXELS-1];
    reg locked;

    // Address of one pixel inside one user area
    function [IDX_W:0] userAddr;
        input area;
        input [IDX_W-1:0] pix;
        begin
            userAddr = {area, pix};
        end
    endfunction

    // Factory set: loadable until locked, then protected until reset
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            locked <= 1'b0;
        end
        else if (factoryLock)
        begin
            locked <= 1'b1;
        end
    end

    always @(posedge clk)
    begin
        if (factoryLoad && !locked)
        begin
            factOfs[writeIndex] <= factoryOffset;
            factGain[writeIndex] <= factoryGain;
        end
        if (writeEnable)
        begin
            userOfs[userAddr(writeSingleArea, writeIndex)] <= writeOffset;
            userGain[userAddr(writeSingleArea, writeIndex)] <= writeGain;
        end
    end

    // Registered read, user area picked by acquisition mode
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readOffset <= {OFS_W{1'b0}};
            readGain <= {GAIN_W{1'b0}};
        end
        else if (useUserSet == `BANK_USER)
        begin
            readOffset <= userOfs[userAddr(singleLineMode, readIndex)];
            readGain <= userGain[userAddr(singleLineMode, readIndex)];
        end
        else
        begin
            readOffset <= factOfs[readIndex];
            readGain <= factGain[readIndex];
        end
    end
endmodule // shading_coeff_store

// ==== dv/pixel_shading_correction_asserts.sv ====
// Port assertions for the shading block
`timescale 1ns/1ps
module pixel_shading_correction_asserts #(
    parameter DATA_W = 12,
    parameter ENHANCED = 0
) (
    // Watched ports
    input wire clk,
    input wire rst,
    input wire [1:0] correctionMode,
    input wire pixelValid,
    input wire lineStart,
    input wire [DATA_W-1:0] pixelIn,
    input wire outValid,
    input wire outLineStart,
    input wire [DATA_W-1:0] pixelOut
);
    reg [1:0] age;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Edges since reset, pipe full at three
    always @(posedge clk or posedge rst)
        if (rst)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    a_valid_delay: assert property (age == 2'h3 |-> outValid == $past(pixelValid, 3))
        else $error("outValid latency wrong");
    a_start_delay: assert property (age == 2'h3 |-> outLineStart == $past(lineStart && pixelValid, 3))
        else $error("outLineStart latency wrong");
    a_start_valid: assert property (outLineStart |-> outValid)
        else $error("line start without pixel");
    a_off_pass: assert property (age == 2'h3 && $past(pixelValid && correctionMode == 2'h0, 3)
        |-> pixelOut == $past(pixelIn, 3)) else $error("off mode altered pixel");
    a_dark_raise: assert property (age == 2'h3 && $past(pixelValid && correctionMode == 2'h1, 3)
        |-> pixelOut >= $past(pixelIn, 3)) else $error("dark offset lowered pixel");
    a_dark_sat: assert property (age == 2'h3 && $past(pixelValid && correctionMode == 2'h1 && &pixelIn, 3)
        |-> &pixelOut) else $error("dark offset did not saturate");
    a_gain_zero: assert property (age == 2'h3 && $past(pixelValid && correctionMode == 2'h2 && pixelIn == 0, 3)
        |-> pixelOut == 0) else $error("gain of zero not zero");
    a_gain_cap: assert property (age == 2'h3 && $past(pixelValid && correctionMode == 2'h2, 3)
        |-> pixelOut * 2 <= $past(pixelIn, 3) * (ENHANCED ? 8 : 3)) else $error("gain above ceiling");
    c_both: cover property (pixelValid && correctionMode == 2'h3);
    c_off: cover property (pixelValid && correctionMode == 2'h0);
    c_line: cover property (outLineStart);
endmodule // pixel_shading_correction_asserts

bind pixel_shading_correction pixel_shading_correction_asserts #(.DATA_W(DATA_W), .ENHANCED(ENHANCED)) chk (
    .clk(clk), .rst(rst), .correctionMode(correctionMode), .pixelValid(pixelValid), .lineStart(lineStart),
    .pixelIn(pixelIn), .outValid(outValid), .outLineStart(outLineStart), .pixelOut(pixelOut));

// ==== dv/sensor_readout_model.sv ====
// Sensor readout model, one line per request
`timescale 1ns/1ps
module sensor_readout_model #(
    parameter PIXELS = 16
) (
    // Bench control
    input wire clk,
    input wire go,
    input wire slow,
    input wire [11:0] value,
    // Pixel stream
    output reg pixelValid = 1'b0,
    output reg lineStart = 1'b0,
    output reg [11:0] pixelIn = 12'h000,
    output reg busy = 1'b0
);
    integer n = 0;
    reg gap = 1'b0;
    // Emit pixels, an idle cycle between them when slow
    always @(posedge clk)
    begin
        if (busy && !gap)
        begin
            pixelValid <= 1'b1;
            lineStart <= n == 0;
            pixelIn <= n == 1 ? 12'h000 : n == 2 ? 12'hfff : value;
            n <= n + 1;
            gap <= slow;
            busy <= n != PIXELS - 1;
        end
        else
        begin
            pixelValid <= 1'b0;
            lineStart <= 1'b0;
            pixelIn <= ~pixelIn; // No stale value when idle
            gap <= 1'b0;
            busy <= busy | go;
            n <= busy ? n : 0;
        end
    end
endmodule // sensor_readout_model

// ==== dv/test_pixel_shading_correction.sv ====
// Self-checking bench for the shading block
`timescale 1ns/1ps
module test_pixel_shading_correction;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [1:0] correctionMode = 2'h0;
    reg useUserSet = 1'b0;
    reg singleLineMode = 1'b0;
    reg go = 1'b0;
    reg slow = 1'b0;
    reg coeffWrite = 1'b0;
    reg coeffSingleArea = 1'b0;
    reg [3:0] coeffIndex = 4'h0;
    reg [11:0] coeffOffset = 12'h000;
    reg [9:0] coeffGain = 10'h000;
    reg factoryLoad = 1'b0;
    reg factoryLock = 1'b0;
    reg locked = 1'b0;
    reg [31:0] lfsr = 32'h283992e7;
    reg [12:0] expq [$];
    reg [12:0] expe [$];
    wire pixelValid, lineStart, outValid, outLineStart, busy;
    wire outValidE, outLineStartE;
    wire [11:0] pixelIn, pixelOut, pixelOutE;
    integer ofs [0:47];
    integer gn [0:47];
    integer idx = 0, i, k, t;
    integer miscompares = 0;
    integer numChecks = 0;
    always #5 clk = ~clk;
    // Random source
    always @(posedge clk)
        lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    sensor_readout_model src (.clk(clk), .go(go), .slow(slow), .value(lfsr[11:0]), .pixelValid(pixelValid),
        .lineStart(lineStart), .pixelIn(pixelIn), .busy(busy));
    pixel_shading_correction #(.ENHANCED(0)) dut (.clk(clk), .rst(rst), .correctionMode(correctionMode),
        .useUserSet(useUserSet), .singleLineMode(singleLineMode), .pixelValid(pixelValid), .lineStart(lineStart),
        .pixelIn(pixelIn), .outValid(outValid), .outLineStart(outLineStart), .pixelOut(pixelOut),
        .coeffWrite(coeffWrite), .coeffSingleArea(coeffSingleArea), .coeffIndex(coeffIndex),
        .coeffOffset(coeffOffset), .coeffGain(coeffGain), .factoryLoad(factoryLoad), .factoryLock(factoryLock),
        .factoryOffset(coeffOffset), .factoryGain(coeffGain));
    // Enhanced-range variant on the same stream
    pixel_shading_correction #(.ENHANCED(1)) dutEnh (.clk(clk), .rst(rst), .correctionMode(correctionMode),
        .useUserSet(useUserSet), .singleLineMode(singleLineMode), .pixelValid(pixelValid), .lineStart(lineStart),
        .pixelIn(pixelIn), .outValid(outValidE), .outLineStart(outLineStartE), .pixelOut(pixelOutE),
        .coeffWrite(coeffWrite), .coeffSingleArea(coeffSingleArea), .coeffIndex(coeffIndex),
        .coeffOffset(coeffOffset), .coeffGain(coeffGain), .factoryLoad(factoryLoad), .factoryLock(factoryLock),
        .factoryOffset(coeffOffset), .factoryGain(coeffGain));
    // Reference result for one pixel, enh selects the variant
    function integer model(input integer p, input integer n, input integer enh);
        integer a, g, d, y, gmax;
    begin
        a = useUserSet ? 16 + 16 * singleLineMode : 0;
        gmax = enh ? 512 : 384;
        g = gn[a + n] > gmax ? gmax : gn[a + n];
        d = p + ofs[a + n] > 4095 ? 4095 : p + ofs[a + n];
        y = ((correctionMode == 2'h3 ? d : p) * g) >> (enh ? 7 : 8);
        model = correctionMode == 2'h0 ? p : correctionMode == 2'h1 ? d : y > 4095 ? 4095 : y;
    end
    endfunction
    // Queue inputs, compare outputs
    always @(posedge clk)
    begin
        if (pixelValid)
        begin
            idx = lineStart ? 0 : idx;
            expq.push_back({lineStart, 12'(model(pixelIn, idx, 0))});
            expe.push_back({lineStart, 12'(model(pixelIn, idx, 1))});
            idx = (idx + 1) % 16;
        end
        if (outValid)
        begin
            numChecks = numChecks + 1;
            if (expq.size() == 0 || {outLineStart, pixelOut} !== expq[0])
            begin
                miscompares = miscompares + 1;
                $display("BAD start,pixelOut expected %h seen %h", expq[0], {outLineStart, pixelOut});
            end
            if (expq.size() != 0)
                void'(expq.pop_front());
        end
        if (outValidE)
        begin
            numChecks = numChecks + 1;
            if (expe.size() == 0 || {outLineStartE, pixelOutE} !== expe[0])
            begin
                miscompares = miscompares + 1;
                $display("BAD enhanced start,pixelOut expected %h seen %h", expe[0], {outLineStartE, pixelOutE});
            end
            if (expe.size() != 0)
                void'(expe.pop_front());
        end
    end
    // Write one coefficient: 0 factory, 1 user normal, 2 user single
    task put(input integer a, input integer n);
    begin
        @(posedge clk);
        coeffIndex <= n[3:0];
        coeffSingleArea <= a == 2;
        coeffOffset <= lfsr[11:0];
        coeffGain <= lfsr[21:12];
        coeffWrite <= a != 0;
        factoryLoad <= a == 0;
        if (a != 0 || !locked)
        begin
            ofs[a * 16 + n] = lfsr[11:0];
            gn[a * 16 + n] = lfsr[21:12];
        end
        @(posedge clk);
        coeffWrite <= 1'b0;
        factoryLoad <= 1'b0;
    end
    endtask
    task finishTest;
    begin
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i = i + 1)
            put(0, i);
        @(posedge clk);
        factoryLock <= 1'b1;
        @(posedge clk);
        factoryLock <= 1'b0;
        locked = 1'b1;
        for (i = 0; i < 48; i = i + 1)
            put(i % 3, i / 3);
        for (k = 0; k < 12; k = k + 1)
        begin
            @(posedge clk);
            correctionMode <= k[1:0];
            useUserSet <= k > 3;
            singleLineMode <= k > 7;
            slow <= k[2];
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            for (t = 0; t < 99 && (t == 0 || busy); t = t + 1)
                @(negedge clk);
            if (busy)
            begin
                miscompares = miscompares + 1;
                finishTest;
            end
        end
        repeat (8) @(negedge clk);
        numChecks = numChecks + 1;
        if (expq.size() != 0 || expe.size() != 0)
        begin
            miscompares = miscompares + 1;
            $display("BAD pending expected 0 seen %0d", expq.size() + expe.size());
        end
        finishTest;
    end
endmodule // test_pixel_shading_correction
